// [hw/pcs_pkg.sv]
/*
 * Package for the card socket signal control block: constants and types
 * shared by the top module and its per-socket status decoder.
 * Assumes one clock at 200 MHz and an active-high asynchronous reset.
 */
// Function
// - Memory mode: low first battery input means card battery dead.
// - I/O mode: first battery input is a status change, may raise interrupt.
// - Memory mode: low second battery input means card battery weak.
// - I/O mode: second battery input is card audio, routed to chip output.
// - With DMA enabled, request comes from battery-warn or write-protect input.
// - An asserted card-detect input means a card is properly seated.
// - Socket A may qualify insertion with two detects; socket B has one.
// - Direction output is high during write cycles, device toward card.
// - Direction output is low during read cycles, card toward device.
// - Direction is coordinated with low and high byte enables for buffers.
// - Each socket has an upper byte enable used when upper byte transfers.
// - Each socket has a lower byte enable used when lower byte transfers.
// - Attribute select high for common memory, low for attribute and I/O.
package pcs_pkg;
    // Output levels of the card-side controls; the byte enables and the attribute select are active low.
    localparam logic BYTE_EN_ON = 1'h0;
    localparam logic BYTE_EN_OFF = 1'h1;
    localparam logic DIR_WRITE = 1'h1;
    localparam logic DIR_READ = 1'h0;
    localparam logic ATTR_SEL_COMMON = 1'h1;
    localparam logic ATTR_SEL_OTHER = 1'h0;
    // Reset value of the audio output.
    localparam logic AUDIO_RST = 1'h0;
    // Selector values for the DMA request source.
    localparam logic DMA_SRC_BATT = 1'h0;
    localparam logic DMA_SRC_WP = 1'h1;

    // Access space of a card cycle.
    typedef enum logic [1:0] {
        PCS_SPACE_COMMON = 2'b00,
        PCS_SPACE_ATTR = 2'b01,
        PCS_SPACE_IO = 2'b10
    } pcs_space_t;

    // Cycle sequencer state.
    typedef enum logic [1:0] {
        PCS_IDLE = 2'b00,
        PCS_ACTIVE = 2'b01
    } pcs_state_t;
endpackage

// [hw/pcs_sock_status.sv]
/*
 * Per-socket status decoder: interprets synchronised battery, write-protect
 * and detect inputs according to the socket's configuration.
 * Assumes its inputs are already synchronised to clk.
 */
`timescale 1ns/1ps
module pcs_sock_status #(
    parameter int DUAL_DETECT = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic io_mode,
    input wire logic dma_en,
    input wire logic dma_src,
    input wire logic dual_det_en,
    input wire logic batt_dead_in,
    input wire logic batt_warn_in,
    input wire logic wp_in,
    input wire logic present_1,
    input wire logic present_2,
    output logic batt_dead_q,
    output logic batt_weak_q,
    output logic status_chg_q,
    output logic card_audio_q,
    output logic dma_req_q,
    output logic seated_q
);
    import pcs_pkg::*;

    logic seated_d;

    // Detects are active low; dual mode needs both pins low.
    always_comb begin
        if (DUAL_DETECT != 0 && dual_det_en) begin
            seated_d = !present_1 && !present_2;
        end else begin
            seated_d = !present_1;
        end
    end

    // Battery status only means something in memory mode.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            batt_dead_q <= 1'h0;
            batt_weak_q <= 1'h0;
        end else begin
            batt_dead_q <= !io_mode && !batt_dead_in;
            batt_weak_q <= !io_mode && !batt_warn_in;
        end
    end

    // In I/O mode the same pins carry status change and audio.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_chg_q <= 1'h0;
            card_audio_q <= 1'h0;
        end else begin
            status_chg_q <= io_mode && !batt_dead_in;
            card_audio_q <= io_mode && batt_warn_in;
        end
    end

    // The DMA request source is a programmable choice of two pins.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dma_req_q <= 1'h0;
        end else begin
            dma_req_q <= dma_en && ((dma_src == DMA_SRC_WP) ? wp_in : batt_warn_in);
        end
    end

    // Seated state is registered so a bouncing contact settles one cycle late.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seated_q <= 1'h0;
        end else begin
            seated_q <= seated_d;
        end
    end

    dead_mem_a: assert property (@(posedge clk) disable iff (rst)
        (!io_mode && !batt_dead_in) |=> batt_dead_q)
        else $error("dead battery not reported");
    chg_io_a: assert property (@(posedge clk) disable iff (rst)
        (io_mode && !batt_dead_in) |=> (status_chg_q && !batt_dead_q))
        else $error("status change not reported");
    weak_mem_a: assert property (@(posedge clk) disable iff (rst)
        (!io_mode && !batt_warn_in) |=> batt_weak_q)
        else $error("weak battery not reported");
    dma_wp_a: assert property (@(posedge clk) disable iff (rst)
        (dma_en && dma_src == DMA_SRC_WP) |=> (dma_req_q == $past(wp_in)))
        else $error("dma request source wrong");
    seat_single_a: assert property (@(posedge clk) disable iff (rst)
        (!dual_det_en && !present_1) |=> seated_q)
        else $error("seated card missed");
endmodule

// [hw/pcs_top.sv]
/*
 * Card socket signal control for two sockets: input synchronisers, status
 * decode, audio routing, and the buffer direction, byte enable and
 * attribute select outputs for each card cycle.
 * Assumes the cycle request comes from same-clock bus logic and holds until
 * cyc_done; card pins are asynchronous and are synchronised here.
 */
`timescale 1ns/1ps
module pcs_top (
    input wire logic clk,
    input wire logic rst,
    // Socket configuration from the controller's own registers.
    input wire logic sock_a_io_mode,
    input wire logic sock_b_io_mode,
    input wire logic sock_a_dma_en,
    input wire logic sock_b_dma_en,
    input wire logic sock_a_dma_src,
    input wire logic sock_b_dma_src,
    input wire logic sock_a_dual_detect,
    input wire logic audio_route_en,
    // Card pins.
    input wire logic sock_a_batt_dead_in,
    input wire logic sock_b_batt_dead_in,
    input wire logic sock_a_batt_warn_in,
    input wire logic sock_b_batt_warn_in,
    input wire logic sock_a_wp_in,
    input wire logic sock_b_wp_in,
    input wire logic sock_a_present_1,
    input wire logic sock_a_present_2,
    input wire logic sock_b_present,
    // Cycle request from the bus side.
    input wire logic cyc_req,
    input wire logic cyc_sock_b,
    input wire logic cyc_write,
    input wire logic cyc_lower,
    input wire logic cyc_upper,
    input wire pcs_pkg::pcs_space_t cyc_space,
    input wire logic cyc_done,
    // Decoded status.
    output logic sock_a_batt_dead,
    output logic sock_b_batt_dead,
    output logic sock_a_batt_weak,
    output logic sock_b_batt_weak,
    output logic sock_a_status_chg,
    output logic sock_b_status_chg,
    output logic sock_a_dma_req,
    output logic sock_b_dma_req,
    output logic sock_a_seated,
    output logic sock_b_seated,
    output logic chip_audio_out,
    // Card buffer controls.
    output logic card_buffer_direction,
    output logic sock_a_lower_byte_en,
    output logic sock_a_upper_byte_en,
    output logic sock_b_lower_byte_en,
    output logic sock_b_upper_byte_en,
    output logic sock_a_attr_sel,
    output logic sock_b_attr_sel,
    output logic cyc_busy
);
    import pcs_pkg::*;

    localparam int NSYNC = 9;

    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic a_audio;
    logic b_audio;
    pcs_state_t state_q;
    logic dir_q;
    logic [1:0] a_en_q;
    logic [1:0] b_en_q;
    logic a_attr_q;
    logic b_attr_q;
    logic audio_q;

    assign pin_raw = {sock_a_batt_dead_in, sock_a_batt_warn_in, sock_a_wp_in,
                      sock_a_present_1, sock_a_present_2, sock_b_batt_dead_in,
                      sock_b_batt_warn_in, sock_b_wp_in, sock_b_present};

    // Two-flop synchronisers; detect pins reset high so no card shows first.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_q <= '1;
            sync2_q <= '1;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
        end
    end

    pcs_sock_status #(.DUAL_DETECT(1)) u_sock_a (
        .clk(clk),
        .rst(rst),
        .io_mode(sock_a_io_mode),
        .dma_en(sock_a_dma_en),
        .dma_src(sock_a_dma_src),
        .dual_det_en(sock_a_dual_detect),
        .batt_dead_in(sync2_q[8]),
        .batt_warn_in(sync2_q[7]),
        .wp_in(sync2_q[6]),
        .present_1(sync2_q[5]),
        .present_2(sync2_q[4]),
        .batt_dead_q(sock_a_batt_dead),
        .batt_weak_q(sock_a_batt_weak),
        .status_chg_q(sock_a_status_chg),
        .card_audio_q(a_audio),
        .dma_req_q(sock_a_dma_req),
        .seated_q(sock_a_seated)
    );

    // Socket B has a single detect pin, so dual qualification is built out.
    pcs_sock_status #(.DUAL_DETECT(0)) u_sock_b (
        .clk(clk),
        .rst(rst),
        .io_mode(sock_b_io_mode),
        .dma_en(sock_b_dma_en),
        .dma_src(sock_b_dma_src),
        .dual_det_en(1'h0),
        .batt_dead_in(sync2_q[3]),
        .batt_warn_in(sync2_q[2]),
        .wp_in(sync2_q[1]),
        .present_1(sync2_q[0]),
        .present_2(1'h1),
        .batt_dead_q(sock_b_batt_dead),
        .batt_weak_q(sock_b_batt_weak),
        .status_chg_q(sock_b_status_chg),
        .card_audio_q(b_audio),
        .dma_req_q(sock_b_dma_req),
        .seated_q(sock_b_seated)
    );

    // Both sockets' audio mix by XOR, the usual way two speaker lines share.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            audio_q <= AUDIO_RST;
        end else begin
            audio_q <= audio_route_en && (a_audio ^ b_audio);
        end
    end
    assign chip_audio_out = audio_q;

    // Cycle sequencer: idle until a request, active until done.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= PCS_IDLE;
        end else begin
            unique case (state_q)
                PCS_IDLE: begin
                    if (cyc_req) begin
                        state_q <= PCS_ACTIVE;
                    end
                end
                PCS_ACTIVE: begin
                    if (cyc_done) begin
                        state_q <= PCS_IDLE;
                    end
                end
                default: begin
                    state_q <= PCS_IDLE;
                end
            endcase
        end
    end

    // Direction and byte enables move together; when idle they fall back to
    // read and off so no buffer fights the card bus.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dir_q <= DIR_READ;
            a_en_q <= {2{BYTE_EN_OFF}};
            b_en_q <= {2{BYTE_EN_OFF}};
        end else if ((state_q == PCS_IDLE) && cyc_req) begin
            dir_q <= cyc_write ? DIR_WRITE : DIR_READ;
            a_en_q[0] <= (!cyc_sock_b && cyc_lower) ? BYTE_EN_ON : BYTE_EN_OFF;
            a_en_q[1] <= (!cyc_sock_b && cyc_upper) ? BYTE_EN_ON : BYTE_EN_OFF;
            b_en_q[0] <= (cyc_sock_b && cyc_lower) ? BYTE_EN_ON : BYTE_EN_OFF;
            b_en_q[1] <= (cyc_sock_b && cyc_upper) ? BYTE_EN_ON : BYTE_EN_OFF;
        end else if ((state_q == PCS_ACTIVE) && cyc_done) begin
            dir_q <= DIR_READ;
            a_en_q <= {2{BYTE_EN_OFF}};
            b_en_q <= {2{BYTE_EN_OFF}};
        end
    end

    // Attribute select is latched per socket for the addressed socket only.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            a_attr_q <= ATTR_SEL_COMMON;
            b_attr_q <= ATTR_SEL_COMMON;
        end else if ((state_q == PCS_IDLE) && cyc_req) begin
            if (cyc_sock_b) begin
                b_attr_q <= (cyc_space == PCS_SPACE_COMMON) ? ATTR_SEL_COMMON
                    : ATTR_SEL_OTHER;
            end else begin
                a_attr_q <= (cyc_space == PCS_SPACE_COMMON) ? ATTR_SEL_COMMON
                    : ATTR_SEL_OTHER;
            end
        end
    end

    assign card_buffer_direction = dir_q;
    assign sock_a_lower_byte_en = a_en_q[0];
    assign sock_a_upper_byte_en = a_en_q[1];
    assign sock_b_lower_byte_en = b_en_q[0];
    assign sock_b_upper_byte_en = b_en_q[1];
    assign sock_a_attr_sel = a_attr_q;
    assign sock_b_attr_sel = b_attr_q;
    assign cyc_busy = (state_q == PCS_ACTIVE);

    wr_dir_a: assert property (@(posedge clk) disable iff (rst)
        ((state_q == PCS_IDLE) && cyc_req && cyc_write)
            |=> (card_buffer_direction && cyc_busy))
        else $error("write direction not high");
    rd_dir_a: assert property (@(posedge clk) disable iff (rst)
        ((state_q == PCS_IDLE) && cyc_req && !cyc_write) |=> !card_buffer_direction)
        else $error("read direction not low");
    upper_en_a: assert property (@(posedge clk) disable iff (rst)
        ((state_q == PCS_IDLE) && cyc_req && !cyc_sock_b && cyc_upper)
            |=> (!sock_a_upper_byte_en && sock_b_upper_byte_en))
        else $error("upper enable wrong");
    lower_en_a: assert property (@(posedge clk) disable iff (rst)
        ((state_q == PCS_IDLE) && cyc_req && cyc_sock_b && cyc_lower)
            |=> (!sock_b_lower_byte_en && sock_a_lower_byte_en))
        else $error("lower enable wrong");
    idle_quiet_a: assert property (@(posedge clk) disable iff (rst)
        !cyc_busy |-> (!card_buffer_direction && sock_a_lower_byte_en && sock_a_upper_byte_en
            && sock_b_lower_byte_en && sock_b_upper_byte_en))
        else $error("buffers active while idle");
    attr_sel_a: assert property (@(posedge clk) disable iff (rst)
        ((state_q == PCS_IDLE) && cyc_req && !cyc_sock_b && cyc_space != PCS_SPACE_COMMON)
            |=> !sock_a_attr_sel)
        else $error("attribute select not low");
    audio_off_a: assert property (@(posedge clk) disable iff (rst)
        !audio_route_en |=> !chip_audio_out)
        else $error("audio passed while disabled");
endmodule

// [dv/pcs_card_model.sv]
/*
 * Card-side model for one socket: detect, battery and write-protect pins.
 * Assumes the bench sets the card's pin levels between sampling edges.
 */
`timescale 1ns/1ps
module pcs_card_model (
    input wire logic seat_1,
    input wire logic seat_2,
    input wire logic lvl_dead,
    input wire logic lvl_warn,
    input wire logic lvl_wp,
    output logic present_1,
    output logic present_2,
    output logic present_any,
    output logic dead_pin,
    output logic warn_pin,
    output logic wp_pin
);
    logic seated;

    // Detect pins are active low; an absent card leaves them at the pull-up level.
    assign present_1 = ~seat_1;
    assign present_2 = ~seat_2;
    // A shared detect line is low only when both card pins are low.
    assign present_any = present_1 | present_2;
    // Pins of a card that is not seated float up, so no stale level is shown.
    assign seated = seat_1 | seat_2;
    assign dead_pin = seated ? lvl_dead : 1'h1;
    assign warn_pin = seated ? lvl_warn : 1'h1;
    assign wp_pin = seated ? lvl_wp : 1'h1;
endmodule

// [dv/tb_top.sv]
/*
 * Self-checking bench for the card socket signal control block.
 * Assumes two card models on the pins and a same-clock cycle requester.
 */
`timescale 1ns/1ps
module tb_top;
    import pcs_pkg::*;
    logic clk = 1'h0, rst = 1'h1, route = 1'h0, a_dual = 1'h1;
    logic a_io = 1'h0, b_io = 1'h0, a_dma = 1'h0, b_dma = 1'h0, a_src = 1'h0, b_src = 1'h0;
    logic a_s1 = 1'h0, a_s2 = 1'h0, a_dead = 1'h1, a_warn = 1'h1, a_wp = 1'h0;
    logic b_s1 = 1'h0, b_s2 = 1'h0, b_dead = 1'h1, b_warn = 1'h1, b_wp = 1'h0;
    logic req = 1'h0, sb = 1'h0, wr = 1'h0, lo = 1'h0, up = 1'h0, done = 1'h0;
    pcs_space_t spc = PCS_SPACE_COMMON;
    logic ap1, ap2, a_dp, a_wn, a_wpp, bp, b_dp, b_wn, b_wpp;
    logic a_bd, b_bd, a_bw, b_bw, a_sc, b_sc, a_dr, b_dr, a_st, b_st, aud;
    logic dir, a_le, a_ue, b_le, b_ue, a_at, b_at, busy;
    int err_count = 0;
    int cmp_count = 0;

    // Free-running 200 MHz clock.
    always #2.5 clk = ~clk;

    pcs_card_model pcs_card_model_a_i (.seat_1(a_s1), .seat_2(a_s2), .lvl_dead(a_dead),
        .lvl_warn(a_warn), .lvl_wp(a_wp), .present_1(ap1), .present_2(ap2),
        .present_any(), .dead_pin(a_dp), .warn_pin(a_wn), .wp_pin(a_wpp));
    pcs_card_model pcs_card_model_b_i (.seat_1(b_s1), .seat_2(b_s2), .lvl_dead(b_dead),
        .lvl_warn(b_warn), .lvl_wp(b_wp), .present_1(), .present_2(),
        .present_any(bp), .dead_pin(b_dp), .warn_pin(b_wn), .wp_pin(b_wpp));

    pcs_top pcs_top_i (.clk(clk), .rst(rst), .sock_a_io_mode(a_io), .sock_b_io_mode(b_io),
        .sock_a_dma_en(a_dma), .sock_b_dma_en(b_dma), .sock_a_dma_src(a_src),
        .sock_b_dma_src(b_src), .sock_a_dual_detect(a_dual), .audio_route_en(route),
        .sock_a_batt_dead_in(a_dp), .sock_b_batt_dead_in(b_dp), .sock_a_batt_warn_in(a_wn),
        .sock_b_batt_warn_in(b_wn), .sock_a_wp_in(a_wpp), .sock_b_wp_in(b_wpp),
        .sock_a_present_1(ap1), .sock_a_present_2(ap2), .sock_b_present(bp),
        .cyc_req(req), .cyc_sock_b(sb), .cyc_write(wr), .cyc_lower(lo), .cyc_upper(up),
        .cyc_space(spc), .cyc_done(done), .sock_a_batt_dead(a_bd), .sock_b_batt_dead(b_bd),
        .sock_a_batt_weak(a_bw), .sock_b_batt_weak(b_bw), .sock_a_status_chg(a_sc),
        .sock_b_status_chg(b_sc), .sock_a_dma_req(a_dr), .sock_b_dma_req(b_dr),
        .sock_a_seated(a_st), .sock_b_seated(b_st), .chip_audio_out(aud),
        .card_buffer_direction(dir), .sock_a_lower_byte_en(a_le),
        .sock_a_upper_byte_en(a_ue), .sock_b_lower_byte_en(b_le),
        .sock_b_upper_byte_en(b_ue), .sock_a_attr_sel(a_at), .sock_b_attr_sel(b_at),
        .cyc_busy(busy));

    task automatic chk(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // Pin changes need two synchroniser stages and a register, so wait past that.
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic t_memory;
        {a_s1, a_s2, b_s1, b_s2} = 4'hF;
        {a_dead, a_warn, b_dead, b_warn} = 4'h6;
        settle(4);
        chk(a_bd, 1'h1);
        chk(b_bd, 1'h0);
        chk(a_bw, 1'h0);
        chk(b_bw, 1'h1);
        {a_dead, b_warn} = 2'h3;
        settle(4);
        chk(a_bd, 1'h0);
        chk(b_bw, 1'h0);
        $display("t_memory done");
    endtask

    task automatic t_io;
        {a_io, b_io, route} = 3'h7;
        {a_dead, a_warn, b_dead, b_warn} = 4'h6;
        settle(5);
        chk(a_sc, 1'h1);
        chk(b_sc, 1'h0);
        chk(aud, 1'h1);
        b_warn = 1'h1;
        settle(5);
        chk(aud, 1'h0);
        {b_warn, route} = 2'h0;
        settle(5);
        chk(aud, AUDIO_RST);
        $display("t_io done");
    endtask

    task automatic t_dma;
        {a_dma, b_dma, a_src, b_src} = {2'h3, DMA_SRC_BATT, DMA_SRC_WP};
        {a_warn, a_wp, b_warn, b_wp} = 4'h9;
        settle(4);
        chk(a_dr, 1'h1);
        chk(b_dr, 1'h1);
        {a_warn, a_wp, b_warn, b_wp} = 4'h6;
        settle(4);
        chk(a_dr, 1'h0);
        chk(b_dr, 1'h0);
        $display("t_dma done");
    endtask

    task automatic t_detect;
        {a_s1, a_s2, b_s1, b_s2} = 4'hA;
        settle(4);
        chk(a_st, 1'h0);
        chk(b_st, 1'h0);
        a_dual = 1'h0;
        settle(4);
        chk(a_st, 1'h1);
        {a_s2, b_s2, a_dual} = 3'h7;
        settle(4);
        chk(a_st, 1'h1);
        chk(b_st, 1'h1);
        $display("t_detect done");
    endtask

    // One card cycle; idles a cycle, then the request holds until done is taken.
    task automatic cyc(input logic b, input logic w, input logic l, input logic u,
        input pcs_space_t s);
        @(negedge clk);
        {req, sb, wr, lo, up, spc} = {1'h1, b, w, l, u, s};
        @(negedge clk);
        chk(busy, 1'h1);
        chk(dir, w ? DIR_WRITE : DIR_READ);
        chk(a_le, (!b && l) ? BYTE_EN_ON : BYTE_EN_OFF);
        chk(a_ue, (!b && u) ? BYTE_EN_ON : BYTE_EN_OFF);
        chk(b_le, (b && l) ? BYTE_EN_ON : BYTE_EN_OFF);
        chk(b_ue, (b && u) ? BYTE_EN_ON : BYTE_EN_OFF);
        chk(b ? b_at : a_at, s == PCS_SPACE_COMMON ? ATTR_SEL_COMMON : ATTR_SEL_OTHER);
        done = 1'h1;
        @(negedge clk);
        {req, done} = 2'h0;
        chk(busy, 1'h0);
        chk(dir, DIR_READ);
        chk(a_le & a_ue & b_le & b_ue, BYTE_EN_OFF);
    endtask

    task automatic t_cycles;
        cyc(1'h0, 1'h1, 1'h0, 1'h1, PCS_SPACE_COMMON);
        cyc(1'h1, 1'h0, 1'h1, 1'h0, PCS_SPACE_ATTR);
        cyc(1'h0, 1'h0, 1'h1, 1'h1, PCS_SPACE_IO);
        cyc(1'h1, 1'h1, 1'h1, 1'h1, PCS_SPACE_COMMON);
        cyc(1'h0, 1'h1, 1'h1, 1'h0, PCS_SPACE_ATTR);
        $display("t_cycles done");
    endtask

    task automatic results;
        $display("%0d comparisons, %0d mismatches", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence: reset for 16 cycles, then the scenarios.
    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'h0;
        chk(dir, DIR_READ);
        chk(a_le & a_ue & b_le & b_ue, BYTE_EN_OFF);
        t_memory();
        t_io();
        t_dma();
        t_detect();
        t_cycles();
        results();
    end

    // The scenarios take about 75 cycles; this bound of 4000 cycles is far beyond that.
    initial begin
        #20000;
        err_count++;
        $display("watchdog expired");
        results();
    end
endmodule
